// file: pkg/ssmis_pkg.sv
// Functional notes
// RULE_01: select high: standby, output lanes released
// RULE_02: host selects once after power-up
// RULE_03: sample on rising, drive after falling
// RULE_04: pause low freezes sequence, not reset
// RULE_05: paused: lane and clock activity ignored
// RULE_06: pause releases/restores output immediately
// RULE_07: host keeps pause high, stays selected
// RULE_08: quad mode: no pause, lane 3 data
// RULE_09: dual mode: lanes 0,1 bidirectional
// RULE_10: spare pin used only in quad
// RULE_11: every operation opens with 8-bit instruction
// RULE_12: all fields most significant bit first
// RULE_13: mode bits 7:6 choose addressing mode
// RULE_14: byte mode moves exactly one byte
// RULE_15: page mode wraps within 32-byte page
// RULE_16: sequential mode wraps top to zero
// RULE_17: write: instruction, address, data bytes
// RULE_18: read streams bytes until deselect
// RULE_19: code 03 reads the array
// RULE_20: code 02 writes the array
// RULE_21: 05 reads, 01 writes mode register
// RULE_22: sequential mode after reset, reserved zero
// RULE_23: 3B enters dual, 38 enters quad
// RULE_24: FF returns to single lane
// RULE_25: deselect aborts command, decoder restarts
// RULE_26: unknown instruction ignored, no drive
package ssmis_pkg;

   // array geometry
   localparam int ADDR_W = 18;
   localparam int MEM_DEPTH = 262144;
   localparam int PAGE_W = 5;

   // bit counts of each field
   localparam logic [4:0] INSTR_BITS = 5'h08;
   localparam logic [4:0] ADDR_BITS = 5'h18;
   localparam logic [4:0] DATA_BITS = 5'h08;
   localparam logic [4:0] CNT_ZERO = 5'h00;

   // instruction codes
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam logic [7:0] OP_ENTER_DUAL = 8'h3B;
   localparam logic [7:0] OP_ENTER_QUAD = 8'h38;
   localparam logic [7:0] OP_EXIT_MULTI = 8'hFF;
   localparam logic [7:0] OP_MODE_RD = 8'h05;
   localparam logic [7:0] OP_MODE_WR = 8'h01;

   // addressing mode field, bits 7:6 of the mode register
   localparam int MODE_MSB = 7;
   localparam int MODE_LSB = 6;
   localparam logic [1:0] MODE_BYTE = 2'h0;
   localparam logic [1:0] MODE_PAGE = 2'h2;
   localparam logic [1:0] MODE_SEQ = 2'h1;
   localparam logic [1:0] MODE_RST = MODE_SEQ;
   localparam logic [5:0] MODE_RSVD = 6'h00;

   // lane width, one-hot
   typedef enum logic [2:0] {
      SSMIS_LANE_SINGLE = 3'b001,
      SSMIS_LANE_DUAL = 3'b010,
      SSMIS_LANE_QUAD = 3'b100
   } ssmis_lane_t;

   // frame sequencer states, one-hot
   typedef enum logic [6:0] {
      SSMIS_ST_CMD = 7'b0000001,
      SSMIS_ST_ADDR = 7'b0000010,
      SSMIS_ST_WR = 7'b0000100,
      SSMIS_ST_RD = 7'b0001000,
      SSMIS_ST_MR_WR = 7'b0010000,
      SSMIS_ST_MR_RD = 7'b0100000,
      SSMIS_ST_IGNORE = 7'b1000000
   } ssmis_state_t;

   // per-frame state on the link clock
   typedef struct packed {
      ssmis_state_t st;
      logic wr_op;
      logic [4:0] cnt;
      logic [23:0] sr;
      logic [ADDR_W-1:0] addr;
   } ssmis_frm_t;

   // persistent configuration on the link clock
   typedef struct packed {
      logic [1:0] mode;
      ssmis_lane_t lane;
   } ssmis_cfg_t;

   // output lanes, updated on falling link clock
   typedef struct packed {
      logic drive;
      logic [3:0] bits;
   } ssmis_out_t;

   // system clock state
   typedef struct packed {
      logic rst_lvl;
      logic [1:0] mode;
      logic dual;
      logic quad;
      logic sel;
   } ssmis_sys_t;

   localparam ssmis_frm_t FRM_RST = '{SSMIS_ST_CMD, 1'b0, 5'h00, 24'h000000, 18'h00000};
   localparam ssmis_cfg_t CFG_RST = '{MODE_RST, SSMIS_LANE_SINGLE};
   localparam ssmis_out_t OUT_RST = '{1'b0, 4'h0};
   localparam ssmis_sys_t SYS_RST = '{1'b1, MODE_RST, 1'b0, 1'b0, 1'b0};

endpackage

// file: verilog/ssmis_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage level synchroniser; first stage feeds only the second
module ssmis_sync #(
   parameter int W = 1
) (
   // destination clock
   input wire logic clk,
   // source level and synchronised copy
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } ssmis_sync_st_t;

   ssmis_sync_st_t st_q; // both stages
   ssmis_sync_st_t st_d;

   // shift the level through two flops
   always_comb begin
      st_d.s1 = din;
      st_d.s2 = st_q.s1;
   end

   // register the stages
   always_ff @(posedge clk) begin
      st_q <= st_d;
   end

   assign dout = st_q.s2;

endmodule
`default_nettype wire

// file: verilog/ssmis_slave.sv
`timescale 1ns/1ps
`default_nettype none
module ssmis_slave (
   // system clock and reset
   input wire logic clk,
   input wire logic srst,
   // link clock and select
   input wire logic sck,
   input wire logic cs_n,
   // lane 0: serial input, dual/quad data
   input wire logic io_lane_0_in,
   output logic io_lane_0_out,
   output logic io_lane_0_oe,
   // lane 1: serial output, dual/quad data
   input wire logic io_lane_1_in,
   output logic io_lane_1_out,
   output logic io_lane_1_oe,
   // lane 2: spare pin, quad data only
   input wire logic io_lane_2_in,
   output logic io_lane_2_out,
   output logic io_lane_2_oe,
   // lane 3: pause (active low), quad data
   input wire logic io_lane_3_in,
   output logic io_lane_3_out,
   output logic io_lane_3_oe,
   // status on the system clock
   output logic [1:0] mode_sts,
   output logic dual_lane_mode,
   output logic quad_lane_mode,
   output logic selected_sts
);

   // memory array, one byte per address
   logic [7:0] mem [0:ssmis_pkg::MEM_DEPTH-1];

   // state of each domain
   ssmis_pkg::ssmis_frm_t frm_q; // cleared by deselect
   ssmis_pkg::ssmis_frm_t frm_d;
   ssmis_pkg::ssmis_cfg_t cfg_q; // survives deselect
   ssmis_pkg::ssmis_cfg_t cfg_d;
   ssmis_pkg::ssmis_out_t out_q; // falling edge outputs
   ssmis_pkg::ssmis_out_t out_d;
   ssmis_pkg::ssmis_sys_t sys_q; // system clock side
   ssmis_pkg::ssmis_sys_t sys_d;

   // internal nets
   logic cfg_rst_s; // reset level seen on link clock
   logic [4:0] sts_s; // status seen on system clock
   logic [3:0] lanes_in; // lane inputs, lane 3 high
   logic is_quad; // quad lane mode active
   logic paused; // pause pin low outside quad
   logic mem_we; // array write strobe
   logic [ssmis_pkg::ADDR_W-1:0] mem_waddr;
   logic [7:0] mem_wdata;

   // bits per clock for the active lane width
   function automatic logic [4:0] lane_width(input ssmis_pkg::ssmis_lane_t lane);
      case (lane)
         ssmis_pkg::SSMIS_LANE_QUAD: lane_width = 5'h04;
         ssmis_pkg::SSMIS_LANE_DUAL: lane_width = 5'h02;
         default: lane_width = 5'h01;
      endcase
   endfunction

   // shift lane bits in at the bottom, earliest bits end up on top
   function automatic logic [23:0] shift_in(input logic [23:0] sr, input logic [3:0] b,
                                            input ssmis_pkg::ssmis_lane_t lane);
      case (lane)
         ssmis_pkg::SSMIS_LANE_QUAD: shift_in = {sr[19:0], b};
         ssmis_pkg::SSMIS_LANE_DUAL: shift_in = {sr[21:0], b[1:0]};
         default: shift_in = {sr[22:0], b[0]};
      endcase
   endfunction

   // next address after a byte, by addressing mode
   function automatic logic [ssmis_pkg::ADDR_W-1:0] next_addr(
      input logic [ssmis_pkg::ADDR_W-1:0] a, input logic [1:0] mode);
      logic [ssmis_pkg::ADDR_W-1:0] inc;
      inc = a + 18'h00001;
      if (mode == ssmis_pkg::MODE_PAGE) begin
         // stay inside the page
         next_addr = {a[ssmis_pkg::ADDR_W-1:ssmis_pkg::PAGE_W], inc[ssmis_pkg::PAGE_W-1:0]}; // RULE_15
      end else begin
         // natural 18-bit roll over to zero
         next_addr = inc; // RULE_16
      end
   endfunction

   assign lanes_in = {io_lane_3_in, io_lane_2_in, io_lane_1_in, io_lane_0_in};
   assign is_quad = (cfg_q.lane == ssmis_pkg::SSMIS_LANE_QUAD);
   // lane 3 is data in quad, so the pause is off there
   assign paused = !is_quad && !io_lane_3_in; // RULE_08

   // reset level carried into the link domain
   ssmis_sync #(
      .W(1)
   ) u_rst_sync (
      .clk(sck),
      .din(sys_q.rst_lvl),
      .dout(cfg_rst_s)
   );

   // configuration and select carried into the system domain
   ssmis_sync #(
      .W(5)
   ) u_sts_sync (
      .clk(clk),
      .din({cfg_q.mode, cfg_q.lane == ssmis_pkg::SSMIS_LANE_DUAL, is_quad, !cs_n}),
      .dout(sts_s)
   );

   // frame sequencer, rising link clock
   always_comb begin
      logic [4:0] w;
      logic [4:0] cnt_nx;
      logic [23:0] sh;
      w = lane_width(cfg_q.lane);
      cnt_nx = frm_q.cnt + w;
      sh = shift_in(frm_q.sr, lanes_in, cfg_q.lane); // RULE_03 RULE_12
      frm_d = frm_q;
      cfg_d = cfg_q;
      mem_we = 1'b0;
      mem_waddr = frm_q.addr;
      mem_wdata = sh[7:0];
      if (paused) begin
         // freeze everything, lanes and clock ignored
         frm_d = frm_q; // RULE_04 RULE_05
      end else begin
         case (frm_q.st)
            ssmis_pkg::SSMIS_ST_CMD: begin
               // collect the instruction byte
               frm_d.sr = sh; // RULE_11
               frm_d.cnt = cnt_nx;
               if (cnt_nx == ssmis_pkg::INSTR_BITS) begin
                  frm_d.cnt = ssmis_pkg::CNT_ZERO;
                  case (sh[7:0])
                     ssmis_pkg::OP_READ: begin
                        frm_d.st = ssmis_pkg::SSMIS_ST_ADDR; // RULE_19
                        frm_d.wr_op = 1'b0;
                     end
                     ssmis_pkg::OP_WRITE: begin
                        frm_d.st = ssmis_pkg::SSMIS_ST_ADDR; // RULE_20
                        frm_d.wr_op = 1'b1;
                     end
                     ssmis_pkg::OP_MODE_RD: begin
                        frm_d.st = ssmis_pkg::SSMIS_ST_MR_RD; // RULE_21
                     end
                     ssmis_pkg::OP_MODE_WR: begin
                        frm_d.st = ssmis_pkg::SSMIS_ST_MR_WR; // RULE_21
                     end
                     ssmis_pkg::OP_ENTER_DUAL: begin
                        cfg_d.lane = ssmis_pkg::SSMIS_LANE_DUAL; // RULE_23 RULE_09
                        frm_d.st = ssmis_pkg::SSMIS_ST_IGNORE;
                     end
                     ssmis_pkg::OP_ENTER_QUAD: begin
                        cfg_d.lane = ssmis_pkg::SSMIS_LANE_QUAD; // RULE_23
                        frm_d.st = ssmis_pkg::SSMIS_ST_IGNORE;
                     end
                     ssmis_pkg::OP_EXIT_MULTI: begin
                        cfg_d.lane = ssmis_pkg::SSMIS_LANE_SINGLE; // RULE_24
                        frm_d.st = ssmis_pkg::SSMIS_ST_IGNORE;
                     end
                     default: begin
                        // unknown code: sit out the frame silently
                        frm_d.st = ssmis_pkg::SSMIS_ST_IGNORE; // RULE_26
                     end
                  endcase
               end
            end
            ssmis_pkg::SSMIS_ST_ADDR: begin
               // 24 address bits, upper six dropped
               frm_d.sr = sh;
               frm_d.cnt = cnt_nx;
               if (cnt_nx == ssmis_pkg::ADDR_BITS) begin
                  frm_d.cnt = ssmis_pkg::CNT_ZERO;
                  frm_d.addr = sh[ssmis_pkg::ADDR_W-1:0]; // RULE_17
                  frm_d.st = frm_q.wr_op ? ssmis_pkg::SSMIS_ST_WR : ssmis_pkg::SSMIS_ST_RD;
               end
            end
            ssmis_pkg::SSMIS_ST_WR: begin
               // assemble a byte, store it, step the address
               frm_d.sr = sh;
               frm_d.cnt = cnt_nx;
               if (cnt_nx == ssmis_pkg::DATA_BITS) begin
                  frm_d.cnt = ssmis_pkg::CNT_ZERO;
                  mem_we = 1'b1; // RULE_17
                  frm_d.addr = next_addr(frm_q.addr, cfg_q.mode);
                  if (cfg_q.mode == ssmis_pkg::MODE_BYTE) begin
                     frm_d.st = ssmis_pkg::SSMIS_ST_IGNORE; // RULE_14
                  end
               end
            end
            ssmis_pkg::SSMIS_ST_RD: begin
               // count bits the host has taken
               frm_d.cnt = cnt_nx;
               if (cnt_nx == ssmis_pkg::DATA_BITS) begin
                  frm_d.cnt = ssmis_pkg::CNT_ZERO;
                  frm_d.addr = next_addr(frm_q.addr, cfg_q.mode); // RULE_18
                  if (cfg_q.mode == ssmis_pkg::MODE_BYTE) begin
                     frm_d.st = ssmis_pkg::SSMIS_ST_IGNORE; // RULE_14
                  end
               end
            end
            ssmis_pkg::SSMIS_ST_MR_WR: begin
               // only the mode field is kept, reserved bits read as zero
               frm_d.sr = sh;
               frm_d.cnt = cnt_nx;
               if (cnt_nx == ssmis_pkg::DATA_BITS) begin
                  frm_d.cnt = ssmis_pkg::CNT_ZERO;
                  cfg_d.mode = sh[ssmis_pkg::MODE_MSB:ssmis_pkg::MODE_LSB]; // RULE_13
                  frm_d.st = ssmis_pkg::SSMIS_ST_IGNORE;
               end
            end
            ssmis_pkg::SSMIS_ST_MR_RD: begin
               // mode register repeats while clocks continue
               frm_d.cnt = (cnt_nx == ssmis_pkg::DATA_BITS) ? ssmis_pkg::CNT_ZERO : cnt_nx;
            end
            ssmis_pkg::SSMIS_ST_IGNORE: begin
               frm_d = frm_q;
            end
            default: begin
               frm_d = ssmis_pkg::FRM_RST;
            end
         endcase
      end
      // system reset restores sequential mode and single lane
      if (cfg_rst_s) begin
         cfg_d = ssmis_pkg::CFG_RST; // RULE_22
      end
   end

   // frame state, wiped whenever select goes high
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         frm_q <= ssmis_pkg::FRM_RST; // RULE_25
      end else begin
         frm_q <= frm_d;
      end
   end

   // persistent configuration
   always_ff @(posedge sck) begin
      cfg_q <= cfg_d;
   end

   // array write port
   always_ff @(posedge sck) begin
      if (mem_we) begin
         mem[mem_waddr] <= mem_wdata;
      end
   end

   // read lanes, falling link clock
   always_comb begin
      logic [7:0] rd_byte;
      logic [7:0] ob;
      rd_byte = mem[frm_q.addr];
      if (frm_q.st == ssmis_pkg::SSMIS_ST_MR_RD) begin
         rd_byte = {cfg_q.mode, ssmis_pkg::MODE_RSVD}; // RULE_21
      end
      ob = rd_byte << frm_q.cnt[2:0]; // RULE_12
      out_d = out_q;
      if (paused) begin
         // hold what is on the lanes
         out_d = out_q; // RULE_05
      end else if (frm_q.st == ssmis_pkg::SSMIS_ST_RD || frm_q.st == ssmis_pkg::SSMIS_ST_MR_RD) begin
         out_d.drive = 1'b1; // RULE_18
         case (cfg_q.lane)
            ssmis_pkg::SSMIS_LANE_QUAD: out_d.bits = ob[7:4];
            ssmis_pkg::SSMIS_LANE_DUAL: out_d.bits = {2'h0, ob[7:6]};
            default: out_d.bits = {2'h0, ob[7], 1'b0};
         endcase
      end else begin
         // nothing to send in any other state
         out_d = ssmis_pkg::OUT_RST; // RULE_26
      end
   end

   // output lanes change only after a falling edge or when select goes high
   always_ff @(negedge sck or posedge cs_n) begin
      if (cs_n) begin
         out_q <= ssmis_pkg::OUT_RST; // RULE_01
      end else begin
         out_q <= out_d; // RULE_03
      end
   end

   // lane data from flops
   assign io_lane_0_out = out_q.bits[0];
   assign io_lane_1_out = out_q.bits[1];
   assign io_lane_2_out = out_q.bits[2];
   assign io_lane_3_out = out_q.bits[3];

   // enables drop at once on deselect or pause
   assign io_lane_1_oe = out_q.drive && !cs_n && (is_quad || io_lane_3_in); // RULE_01 RULE_06
   assign io_lane_0_oe = out_q.drive && !cs_n && !cfg_q.lane[0] && (is_quad || io_lane_3_in); // RULE_09
   assign io_lane_2_oe = out_q.drive && !cs_n && is_quad; // RULE_10
   assign io_lane_3_oe = out_q.drive && !cs_n && is_quad; // RULE_08

   // system side: reset level and status registers
   always_comb begin
      sys_d.rst_lvl = srst;
      sys_d.mode = sts_s[4:3];
      sys_d.dual = sts_s[2];
      sys_d.quad = sts_s[1];
      sys_d.sel = sts_s[0];
      if (srst) begin
         sys_d = ssmis_pkg::SYS_RST;
      end
   end

   // register system side
   always_ff @(posedge clk) begin
      sys_q <= sys_d;
   end

   assign mode_sts = sys_q.mode;
   assign dual_lane_mode = sys_q.dual;
   assign quad_lane_mode = sys_q.quad;
   assign selected_sts = sys_q.sel;

endmodule
`default_nettype wire

// file: verif/ssmis_slave_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ssmis_slave_checker (
   // clocks, reset, select
   input wire logic clk,
   input wire logic srst,
   input wire logic sck,
   input wire logic cs_n,
   // lanes
   input wire logic io_lane_0_oe,
   input wire logic io_lane_1_out,
   input wire logic io_lane_1_oe,
   input wire logic io_lane_2_oe,
   input wire logic io_lane_3_in,
   input wire logic io_lane_3_oe,
   // status
   input wire logic [1:0] mode_sts,
   input wire logic dual_lane_mode,
   input wire logic quad_lane_mode,
   input wire logic selected_sts
);
   logic hi_q; // lane 1 level at the last rise
   // capture output at each rise; it must hold until the fall
   always_ff @(posedge sck) begin
      hi_q <= io_lane_1_out;
   end
   property p_desel_idle;
      @(posedge clk) disable iff (srst)
      cs_n |-> !(|{io_lane_0_oe, io_lane_1_oe, io_lane_2_oe, io_lane_3_oe});
   endproperty
   a_desel_idle: assert property (p_desel_idle) else $error("lane driven while deselected");
   property p_sel_sts;
      @(posedge clk) disable iff (srst) $fell(cs_n) |-> ##[2:5] selected_sts;
   endproperty
   a_sel_sts: assert property (p_sel_sts) else $error("select not reported");
   property p_desel_sts;
      @(posedge clk) disable iff (srst) $rose(cs_n) |-> ##[2:5] !selected_sts;
   endproperty
   a_desel_sts: assert property (p_desel_sts) else $error("deselect not reported");
   property p_rst_sts;
      @(posedge clk) disable iff (srst) $past(srst) |->
      (mode_sts == ssmis_pkg::MODE_RST) && !dual_lane_mode && !quad_lane_mode && !selected_sts;
   endproperty
   a_rst_sts: assert property (p_rst_sts) else $error("status wrong after reset");
   property p_pause_off;
      @(posedge clk) disable iff (srst)
      (!quad_lane_mode && !io_lane_3_in) |-> !io_lane_0_oe && !io_lane_1_oe;
   endproperty
   a_pause_off: assert property (p_pause_off) else $error("output driven while paused");
   property p_quad_only;
      @(posedge clk) disable iff (srst) !quad_lane_mode |-> !io_lane_2_oe && !io_lane_3_oe;
   endproperty
   a_quad_only: assert property (p_quad_only) else $error("lane 2 or 3 driven");
   property p_single_in;
      @(posedge clk) disable iff (srst)
      !(dual_lane_mode || quad_lane_mode) |-> !io_lane_0_oe;
   endproperty
   a_single_in: assert property (p_single_in) else $error("lane 0 driven in single");
   property p_out_fall;
      @(negedge sck) disable iff (srst) (!cs_n && io_lane_1_oe) |-> io_lane_1_out == hi_q;
   endproperty
   a_out_fall: assert property (p_out_fall) else $error("output moved while clock high");
   // main scenarios reached
   c_quad: cover property (@(posedge clk) io_lane_3_oe);
   c_dual: cover property (@(posedge clk) io_lane_0_oe && dual_lane_mode);
   c_pause: cover property (@(posedge clk) !cs_n && !io_lane_3_in && !quad_lane_mode);
endmodule
bind ssmis_slave ssmis_slave_checker i_chk (
   .clk(clk), .srst(srst), .sck(sck), .cs_n(cs_n),
   .io_lane_0_oe(io_lane_0_oe), .io_lane_1_out(io_lane_1_out), .io_lane_1_oe(io_lane_1_oe),
   .io_lane_2_oe(io_lane_2_oe), .io_lane_3_in(io_lane_3_in), .io_lane_3_oe(io_lane_3_oe),
   .mode_sts(mode_sts), .dual_lane_mode(dual_lane_mode),
   .quad_lane_mode(quad_lane_mode), .selected_sts(selected_sts)
);
`default_nettype wire

// file: verif/ssmis_host.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural host; sck runs only when tick is called, also outside frames, and starts idle
module ssmis_host (
   // link control
   output logic sck,
   output logic cs_n,
   // resolved lane levels, slave drive
   output logic [3:0] lane_in,
   input wire logic [3:0] lane_out,
   input wire logic [3:0] lane_oe
);
   logic [3:0] hd = 4'h8; // host data, pause high on lane 3
   logic [3:0] hoe = 4'h8; // host enables
   logic [3:0] smp; // lanes sampled at the rise
   logic tg = 1'b0; // floating lane pattern
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
   end
   // a floating lane never keeps its last value
   always #5 tg = ~tg;
   // slave wins, then host, else floating
   always_comb begin
      for (int i = 0; i < 4; i++) lane_in[i] = lane_oe[i] ? lane_out[i] : (hoe[i] ? hd[i] : tg);
   end
   // one clock: low half, rise and sample, high half, fall
   task automatic tick();
      #7.5;
      sck = 1'b1;
      smp = lane_in;
      #7.5;
      sck = 1'b0;
   endtask
   // select a full period before the first rise
   task automatic sel();
      cs_n = 1'b0;
      #7.5;
   endtask
   // end frame, release data lanes, pause back high
   task automatic desel();
      cs_n = 1'b1;
      hoe = 4'h8;
      hd = 4'h8;
      #100;
   endtask
   // send a byte, most significant first, w bits a clock
   task automatic put(input logic [7:0] b, input int w);
      hoe = (w == 4) ? 4'hF : ((w == 2) ? 4'hB : 4'h9);
      for (int i = 8 - w; i >= 0; i -= w) begin
         if (w == 4) hd = b[i+:4];
         else if (w == 2) hd[1:0] = b[i+:2];
         else hd[0] = b[i];
         tick();
      end
   endtask
   // receive a byte in the same order
   task automatic get(input int w, output logic [7:0] b);
      hoe = (w == 4) ? 4'h0 : 4'h8;
      for (int i = 8 - w; i >= 0; i -= w) begin
         tick();
         if (w == 4) b[i+:4] = smp;
         else if (w == 2) b[i+:2] = smp[1:0];
         else b[i] = smp[1];
      end
   endtask
endmodule
`default_nettype wire

// file: verif/ssmis_slave_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ssmis_slave_tb;
   logic clk = 1'b0; // system clock
   logic srst = 1'b1; // reset
   logic sck, cs_n; // link clock, select
   logic [3:0] lin; // lanes seen by the slave
   wire [3:0] lout, loe; // slave lane drive, one port per bit
   logic [1:0] mode_sts; // status
   logic dual_lane_mode, quad_lane_mode, selected_sts;
   int bad_count = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [7:0] ref_mem [0:262143]; // expected array
   logic [1:0] md = ssmis_pkg::MODE_RST; // expected mode
   int lw = 1; // lane width
   logic [23:0] a;
   logic [7:0] d;
   ssmis_slave i_dut (
      .clk(clk), .srst(srst), .sck(sck), .cs_n(cs_n),
      .io_lane_0_in(lin[0]), .io_lane_0_out(lout[0]), .io_lane_0_oe(loe[0]),
      .io_lane_1_in(lin[1]), .io_lane_1_out(lout[1]), .io_lane_1_oe(loe[1]),
      .io_lane_2_in(lin[2]), .io_lane_2_out(lout[2]), .io_lane_2_oe(loe[2]),
      .io_lane_3_in(lin[3]), .io_lane_3_out(lout[3]), .io_lane_3_oe(loe[3]),
      .mode_sts(mode_sts), .dual_lane_mode(dual_lane_mode),
      .quad_lane_mode(quad_lane_mode), .selected_sts(selected_sts)
   );
   ssmis_host i_host (.sck(sck), .cs_n(cs_n), .lane_in(lin), .lane_out(lout), .lane_oe(loe));
   always #5 clk = ~clk;
   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         print_verdict();
      end
   end
   task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // next address for the current mode
   function automatic logic [17:0] nxt(input logic [17:0] p);
      if (md == ssmis_pkg::MODE_PAGE) return {p[17:5], p[4:0] + 5'h01};
      return p + 18'h00001;
   endfunction
   // instruction and address
   task automatic hdr(input logic [7:0] op, input logic [23:0] ad);
      i_host.sel();
      i_host.put(op, lw);
      for (int i = 16; i >= 0; i -= 8) i_host.put(ad[i+:8], lw);
   endtask
   task automatic wr(input logic [23:0] ad, input int n);
      logic [17:0] p;
      logic [7:0] v;
      p = ad[17:0];
      hdr(ssmis_pkg::OP_WRITE, ad);
      for (int i = 0; i < n; i++) begin
         v = 8'($urandom);
         i_host.put(v, lw);
         if (md != ssmis_pkg::MODE_BYTE || i == 0) ref_mem[p] = v;
         p = nxt(p);
      end
      i_host.desel();
   endtask
   task automatic rd(input logic [23:0] ad, input int n);
      logic [17:0] p;
      logic [7:0] v;
      p = ad[17:0];
      hdr(ssmis_pkg::OP_READ, ad);
      for (int i = 0; i < n; i++) begin
         i_host.get(lw, v);
         check("read", v, ref_mem[p]);
         p = nxt(p);
      end
      #1;
      if (md == ssmis_pkg::MODE_BYTE) check("byte_oe", {7'h00, loe[1]}, 8'h00);
      i_host.desel();
   endtask
   // optional mode write, then read back
   task automatic mode(input logic w_en, input logic [1:0] m);
      logic [7:0] v;
      if (w_en) begin
         i_host.sel();
         i_host.put(ssmis_pkg::OP_MODE_WR, lw);
         i_host.put({m, ssmis_pkg::MODE_RSVD}, lw);
         i_host.desel();
      end
      md = m;
      i_host.sel();
      i_host.put(ssmis_pkg::OP_MODE_RD, lw);
      i_host.get(lw, v);
      i_host.desel();
      check("mode_reg", v, {m, ssmis_pkg::MODE_RSVD});
      check("mode_sts", {6'h00, mode_sts}, {6'h00, m});
   endtask
   task automatic lanes(input logic [7:0] op, input int w);
      i_host.sel();
      i_host.put(op, lw);
      i_host.desel();
      lw = w;
      check("lane_sts", {6'h00, dual_lane_mode, quad_lane_mode}, {6'h00, w == 2, w == 4});
   endtask
   // pause with sck low, junk on lane 0, then resume
   // pause moves clear of the falling edge so the output flops see one level
   task automatic pz(input logic oe_exp);
      #2 i_host.hd[3] = 1'b0;
      #1 check("oe_paused", {7'h00, loe[1]}, 8'h00);
      repeat (3) begin
         i_host.hd[0] = 1'($urandom);
         i_host.tick();
      end
      #2 i_host.hd[3] = 1'b1;
      #1 check("oe_resumed", {7'h00, loe[1]}, {7'h00, oe_exp});
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      void'($urandom(47));
      fork
         repeat (7) i_host.tick();
         repeat (12) @(posedge clk);
      join
      #1 srst = 1'b0;
      repeat (4) i_host.tick();
      mode(1'b0, ssmis_pkg::MODE_RST);
      wr({6'h2A, 18'h3FFFE}, 4);
      rd(24'h03FFFE, 4);
      mode(1'b1, ssmis_pkg::MODE_PAGE);
      a = {6'h00, 13'($urandom), 5'h1E};
      wr(a, 34);
      rd(a, 32);
      mode(1'b1, ssmis_pkg::MODE_BYTE);
      a = 24'($urandom);
      wr(a, 2);
      rd(a, 1);
      mode(1'b1, ssmis_pkg::MODE_SEQ);
      // partial byte dropped at deselect
      a = 24'($urandom);
      wr(a, 1);
      hdr(ssmis_pkg::OP_WRITE, a);
      repeat (5) i_host.tick();
      i_host.desel();
      rd(a, 1);
      hdr(8'h5A, a);
      i_host.get(1, d);
      check("oe_unknown", {7'h00, loe[1]}, 8'h00);
      i_host.desel();
      // pause inside the address and after it
      i_host.sel();
      i_host.put(ssmis_pkg::OP_READ, 1);
      i_host.put(a[23:16], 1);
      pz(1'b0);
      i_host.put(a[15:8], 1);
      i_host.put(a[7:0], 1);
      pz(1'b1);
      i_host.get(1, d);
      check("paused_read", d, ref_mem[a[17:0]]);
      i_host.desel();
      for (int k = 0; k < 2; k++) begin
         lanes(k ? ssmis_pkg::OP_ENTER_QUAD : ssmis_pkg::OP_ENTER_DUAL, k ? 4 : 2);
         a = 24'($urandom);
         wr(a, 3);
         rd(a, 3);
         lanes(ssmis_pkg::OP_EXIT_MULTI, 1);
      end
      print_verdict();
   end
endmodule
`default_nettype wire
